//--- core/cssc_params.svh
// Functional notes
// R01 - select codes 0001..0100 run internal RC at nominal 1, 2, 4, 8 MHz
// R02 - delivered fuses select 1 MHz RC and 65 ms reset delay code
// R03 - during reset hardware copies factory calibration byte into trim register
// R04 - reset trim value is the 1 MHz byte from signature row location 0x00
// R05 - software loads trim itself for RC frequencies other than 1 MHz
// R06 - trim zero is slowest, larger values faster, all ones fastest
// R07 - RC start-up: 6 cycles from power-down; reset delay none, 4.1 ms, 65 ms
// R08 - select code 0000 takes system clock from external clock input pin
// R09 - external clock: 6 cycles from power-down, same three reset delays
// R10 - watchdog oscillator still times watchdog and reset time-out
// R11 - configurer should leave oscillator option fuse unprogrammed with RC clock
// R12 - calibrated RC oscillator times nonvolatile memory access; code sets nvm_timebase_rc only while an RC select code is active
// R13 - software must not trim over 10 percent above nominal during NVM writes
// R14 - external clock changes over 2 percent per cycle need reset held
// R15 - trim register read and write at any time, effect without reset
`ifndef CSSC_PARAMS_SVH
`define CSSC_PARAMS_SVH

// ----------------------------------------
// fuse codes and delivered values
// ----------------------------------------
`define CSSC_SEL_EXT        4'h0
`define CSSC_SEL_RC1        4'h1
`define CSSC_SEL_RC2        4'h2
`define CSSC_SEL_RC4        4'h3
`define CSSC_SEL_RC8        4'h4
`define CSSC_SEL_DELIVERED  4'h1
`define CSSC_SUT_NONE       2'h0
`define CSSC_SUT_SHORT      2'h1
`define CSSC_SUT_LONG       2'h2
`define CSSC_SUT_DELIVERED  2'h2
`define CSSC_SIG_CAL_ADDR   8'h00

// ----------------------------------------
// register map
// ----------------------------------------
`define CSSC_ADDR_TRIM      8'h00
`define CSSC_ADDR_STATUS    8'h01
`define CSSC_ADDR_FUSES     8'h02
`define CSSC_TRIM_RESET     8'h00

// ----------------------------------------
// timing
// ----------------------------------------
`define CSSC_CLK_MHZ        125
`define CSSC_PD_START_CK    6
`define CSSC_SHORT_US       4100
`define CSSC_LONG_US        65000
`define CSSC_SHORT_CYC      (`CSSC_SHORT_US * `CSSC_CLK_MHZ)
`define CSSC_LONG_CYC       (`CSSC_LONG_US * `CSSC_CLK_MHZ)

`endif

//--- core/cssc_pkg.sv
package cssc_pkg;
    typedef enum logic [1:0] {
        CSSC_SRC_EXT,
        CSSC_SRC_RC,
        CSSC_SRC_BAD
    } cssc_src_t;

    typedef enum logic [1:0] {
        CSSC_RUN,
        CSSC_DELAY,
        CSSC_PD,
        CSSC_WAKE
    } cssc_phase_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } cssc_bus_t;

    typedef struct packed {
        logic [3:0] clock_select_fuses;
        logic [1:0] startup_time_fuses;
        logic       oscillator_option_fuse;
    } cssc_fuse_t;
endpackage

//--- core/cssc_top.sv
`include "cssc_params.svh"

module cssc_top
    import cssc_pkg::*;
#(
    parameter int unsigned SHORT_CYC = `CSSC_SHORT_CYC,
    parameter int unsigned LONG_CYC  = `CSSC_LONG_CYC
) (
    input  wire logic         clock,
    input  wire logic         rst_n,
    input  wire cssc_bus_t    bus,
    output logic       [7:0]  rdata,
    input  wire cssc_fuse_t   fuses,
    input  wire logic  [7:0]  sig_row_data,
    output logic       [7:0]  sig_row_addr,
    input  wire logic         power_down_req,
    input  wire logic         wake_req,
    input  wire logic         clock_input_pin,
    input  wire logic         watchdog_tick,
    output logic              use_external_clock,
    output logic              use_rc_clock,
    output logic       [3:0]  rc_freq_mhz,
    output logic       [7:0]  trim_value,
    output logic              system_clock_enable,
    output logic              cpu_ready,
    output logic              nvm_timebase_rc,
    output logic              option_fuse_warning
);

    typedef struct packed {
        logic [7:0]  trim;
        logic [7:0]  rdata;
        cssc_phase_t phase;
        logic [23:0] cnt;
        logic        in_reset;
        logic        ext_q;
    } cssc_state_t;

    cssc_state_t st_ff;
    cssc_state_t nxt_st;
    cssc_src_t   src;
    logic [23:0] delay_cyc;

    // ----------------------------------------
    // fuse decode
    // ----------------------------------------
    always_comb begin
        src         = CSSC_SRC_BAD;
        rc_freq_mhz = 4'h0;
        unique case (fuses.clock_select_fuses)
            `CSSC_SEL_EXT: src = CSSC_SRC_EXT; // R08
            `CSSC_SEL_RC1: begin
                src         = CSSC_SRC_RC; // R01
                rc_freq_mhz = 4'h1;
            end
            `CSSC_SEL_RC2: begin
                src         = CSSC_SRC_RC; // R01
                rc_freq_mhz = 4'h2;
            end
            `CSSC_SEL_RC4: begin
                src         = CSSC_SRC_RC; // R01
                rc_freq_mhz = 4'h4;
            end
            `CSSC_SEL_RC8: begin
                src         = CSSC_SRC_RC; // R01
                rc_freq_mhz = 4'h8;
            end
            default: src = CSSC_SRC_BAD;
        endcase
        // reset delay, counted on watchdog ticks (R10); reserved code treated as longest
        unique case (fuses.startup_time_fuses)
            `CSSC_SUT_NONE:  delay_cyc = 24'h0; // R07 R09
            `CSSC_SUT_SHORT: delay_cyc = 24'(SHORT_CYC); // R07 R09
            default:         delay_cyc = 24'(LONG_CYC); // R07 R09 R02
        endcase
    end

    assign use_external_clock  = (src == CSSC_SRC_EXT); // R08
    assign use_rc_clock        = (src == CSSC_SRC_RC); // R01
    assign trim_value          = st_ff.trim; // R06 R15
    assign nvm_timebase_rc     = use_rc_clock; // R12
    assign option_fuse_warning = use_rc_clock & ~fuses.oscillator_option_fuse; // R11
    assign sig_row_addr        = `CSSC_SIG_CAL_ADDR; // R04
    assign cpu_ready           = (st_ff.phase == CSSC_RUN) & ~st_ff.in_reset;
    assign system_clock_enable = cpu_ready & (use_rc_clock | st_ff.ext_q); // R08
    assign rdata               = st_ff.rdata;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        nxt_st          = st_ff;
        nxt_st.in_reset = 1'b0;
        nxt_st.ext_q    = clock_input_pin;
        nxt_st.rdata    = 8'h00;
        // trim writable at any time, effective at once
        if (bus.wr && bus.addr == `CSSC_ADDR_TRIM) begin
            nxt_st.trim = bus.wdata; // R15
        end
        if (bus.rd) begin
            unique case (bus.addr)
                `CSSC_ADDR_TRIM:   nxt_st.rdata = st_ff.trim; // R15
                `CSSC_ADDR_STATUS: nxt_st.rdata = {4'h0, cpu_ready, use_rc_clock,
                                                   use_external_clock, st_ff.phase != CSSC_RUN};
                `CSSC_ADDR_FUSES:  nxt_st.rdata = {1'b0, fuses.oscillator_option_fuse,
                                                   fuses.startup_time_fuses,
                                                   fuses.clock_select_fuses};
                default:           nxt_st.rdata = 8'h00;
            endcase
        end
        unique case (st_ff.phase)
            CSSC_RUN: begin
                if (st_ff.in_reset) begin
                    nxt_st.cnt   = delay_cyc;
                    nxt_st.phase = (delay_cyc == 24'h0) ? CSSC_RUN : CSSC_DELAY;
                end else if (power_down_req) begin
                    nxt_st.phase = CSSC_PD;
                end
            end
            CSSC_DELAY: begin
                // time-out runs off the watchdog oscillator
                if (watchdog_tick) begin
                    nxt_st.cnt = st_ff.cnt - 24'h1; // R10
                    if (st_ff.cnt == 24'h1) begin
                        nxt_st.phase = CSSC_RUN;
                    end
                end
            end
            CSSC_PD: begin
                if (wake_req) begin
                    nxt_st.cnt   = 24'(`CSSC_PD_START_CK); // R07 R09
                    nxt_st.phase = CSSC_WAKE;
                end
            end
            CSSC_WAKE: begin
                nxt_st.cnt = st_ff.cnt - 24'h1;
                if (st_ff.cnt == 24'h1) begin
                    nxt_st.phase = CSSC_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            st_ff          <= '0;
            st_ff.trim     <= sig_row_data; // R03 R04
            st_ff.phase    <= CSSC_RUN;
            st_ff.in_reset <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

endmodule // cssc_top

//--- sim/cssc_ext_clock.sv
// ----------
// far-side clock source
// ----------
module cssc_ext_clock (
    input  wire logic clock,
    input  wire logic enable,
    output logic      pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // fixed divide-by-two: no jump in period between cycles, still when unused
    always_ff @(posedge clock) begin
        pin <= enable ? ~pin : 1'b0;
    end
endmodule // cssc_ext_clock

//--- sim/cssc_sva.sv
// ----------
// port checks
// ----------
module cssc_sva
    import cssc_pkg::*;
(
    input wire logic       clock,
    input wire logic       rst_n,
    input wire cssc_bus_t  bus,
    input wire cssc_fuse_t fuses,
    input wire logic [7:0] sig_row_data,
    input wire logic [7:0] rdata,
    input wire logic [7:0] trim_value,
    input wire logic       use_external_clock,
    input wire logic       use_rc_clock,
    input wire logic [3:0] rc_freq_mhz,
    input wire logic       cpu_ready,
    input wire logic       nvm_timebase_rc,
    input wire logic [7:0] sig_row_addr,
    input wire logic       option_fuse_warning,
    input wire logic       system_clock_enable
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    wire [3:0] s = fuses.clock_select_fuses;
    chk_ext_sel: assert property (use_external_clock == (s == 4'h0)) else $error("ext sel");
    chk_rc_freq: assert property (use_rc_clock |-> rc_freq_mhz == 4'h1 << (s - 4'h1))
        else $error("rc freq");
    chk_trim_load: assert property (disable iff (1'b0)
        !rst_n |=> trim_value == $past(sig_row_data))
        else $error("trim load");
    chk_trim_wr: assert property (bus.wr && bus.addr == 8'h00
        |=> trim_value == $past(bus.wdata))
        else $error("trim write");
    chk_trim_rd: assert property (bus.rd && bus.addr == 8'h00
        |=> rdata == $past(trim_value))
        else $error("trim read");
    chk_rdata_idle: assert property (!$past(bus.rd) |-> rdata == 8'h00)
        else $error("rdata idle");
    chk_nvm_rc: assert property (nvm_timebase_rc == use_rc_clock) else $error("nvm base");
    // reset is synchronous: ready drops at the first edge that sees it
    chk_ready_rst: assert property (disable iff (1'b0) !rst_n |=> !cpu_ready)
        else $error("ready in reset");
    chk_sig_addr: assert property (sig_row_addr == 8'h00) else $error("sig addr");
    chk_opt_warn: assert property (option_fuse_warning ==
        (use_rc_clock && !fuses.oscillator_option_fuse))
        else $error("option warning");
    chk_sysclk_en: assert property (system_clock_enable |-> cpu_ready)
        else $error("clock enable");
    cover property (bus.wr && bus.addr == 8'h00);
    cover property (use_external_clock && cpu_ready);
    cover property ($rose(cpu_ready));
endmodule // cssc_sva
bind cssc_top cssc_sva cssc_sva_inst (.*);

//--- sim/cssc_top_tb.sv
module cssc_top_tb import cssc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock = 1'b0, rst_n = 1'b0, pdr = 1'b0, wkr = 1'b0, tick = 1'b0, pin;
    logic        use_external_clock, use_rc_clock, cpu_ready;
    logic [3:0]  rc_freq_mhz;
    logic [7:0]  rdata, trim_value, sig = 8'h00, d, w;
    cssc_bus_t   bus = '0;
    cssc_fuse_t  fuses = '{4'h1, 2'h2, 1'b1};
    logic [31:0] lf = 32'hcc45;
    int          error_cnt = 0, num_checks = 0, cyc = 0, n;
    cssc_ext_clock cssc_ext_clock_inst (.clock, .enable(use_external_clock), .pin);
    cssc_top #(.SHORT_CYC(4), .LONG_CYC(8)) cssc_top_inst (.clock, .rst_n, .bus, .rdata, .fuses,
        .sig_row_data(sig), .sig_row_addr(), .power_down_req(pdr), .wake_req(wkr),
        .clock_input_pin(pin), .watchdog_tick(tick), .use_external_clock, .use_rc_clock,
        .rc_freq_mhz, .trim_value, .system_clock_enable(), .cpu_ready, .nvm_timebase_rc(),
        .option_fuse_warning());
    initial forever #4 clock = ~clock;
    always @(posedge clock) begin
        tick <= ~tick;
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            error_cnt++;
            conclude();
        end
    end
    function logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function logic [3:0] mhz(int s);
        return (s >= 1 && s <= 4) ? 4'(1 << (s - 1)) : 4'h0;
    endfunction
    // lower edge of the wait window, in clocks, per start-up code
    function int lo(int u);
        return u == 0 ? 0 : u == 1 ? 6 : 14;
    endfunction
    task chk(string nm, logic [7:0] e, logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task acc(logic [7:0] a, logic [7:0] wd, logic r);
        @(posedge clock);
        bus <= '{a, wd, !r, r};
        @(posedge clock);
        bus <= '0;
        #1 d = rdata;
    endtask
    task conclude();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        for (int u = 5; u >= 0; u--) begin
            lf = lfsr(lf);
            rst_n <= 1'b0;
            sig <= lf[7:0];
            fuses <= '{4'(u), 2'(u % 4), 1'b1};
            repeat (6) @(posedge clock);
            rst_n <= 1'b1;
            #1 chk("trim rst", sig, trim_value);
            chk("mhz", 8'(mhz(u)), 8'(rc_freq_mhz));
            for (n = 0; n < 40 && cpu_ready !== 1'b1; n++) @(posedge clock) #1;
            chk("delay", 8'h01, 8'(n >= lo(u % 4) && n <= lo(u % 4) + 6));
        end
        $display("test reset end");
        for (int i = 0; i < 24; i++) begin
            lf = lfsr(lf);
            w = i == 0 ? 8'h00 : i == 1 ? 8'hff : lf[7:0];
            acc(8'h00, w, 1'b0);
            chk("trim wr", w, trim_value);
            acc(8'h00, 8'h00, 1'b1);
            chk("trim rd", w, d);
        end
        acc(8'h05, 8'h3c, 1'b0);
        acc(8'h05, 8'h00, 1'b1);
        chk("unmapped", 8'h00, d);
        chk("trim kept", w, trim_value);
        acc(8'h02, 8'h00, 1'b1);
        chk("fuses", {1'b0, 1'b1, 2'h0, 4'h0}, d);
        $display("test trim end");
        pdr <= 1'b1;
        @(posedge clock);
        pdr <= 1'b0;
        repeat (3) @(posedge clock);
        #1 chk("pd", 8'h00, 8'(cpu_ready));
        wkr <= 1'b1;
        @(posedge clock);
        wkr <= 1'b0;
        for (n = 0; n < 40 && cpu_ready !== 1'b1; n++) @(posedge clock) #1;
        chk("wake", 8'h01, 8'(n >= 5 && n <= 8));
        acc(8'h01, 8'h00, 1'b1);
        chk("status", 8'h0a, d);
        $display("test wake end");
        conclude();
    end
endmodule // cssc_top_tb
